// ==== core/port_b_change_and_mux.sv ====
// Second I/O port with change detection, wake, peripheral overrides and counter clock muxing.
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module port_b_change_and_mux #(
    parameter int port_width = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    input wire logic [port_width-1:0] pin_in,
    output logic [port_width-1:0] pin_out,
    output logic [port_width-1:0] pin_oe,
    input wire logic [3:1] periph_out,
    input wire logic [3:1] periph_force_out,
    input wire logic [3:1] periph_force_in,
    input wire logic sleeping,
    output logic wake_request,
    output logic count_clock,
    output logic aux_osc_active,
    output logic irq
);
    logic [port_width-1:0] pin_s1_reg;
    logic [port_width-1:0] pin_s2_reg;
    logic [3:0] schmitt_reg;
    logic [3:0] s3_reg;
    logic [port_width-1:0] latch_reg;
    logic [port_width-1:0] direction_reg;
    logic [3:0] snapshot_reg;
    logic port_change_flag_reg;
    logic port_change_enable_reg;
    logic [5:0] counter_control_reg;
    logic firmware_clock_pin_reg;
    logic ext_clock_pin_select_reg;
    logic [3:1] periph_enable_reg;
    logic [1:0] int_status_reg;
    logic [1:0] int_mask_reg;
    logic [port_width-1:0] pin_level;
    logic [port_width-1:0] eff_dir;
    logic [port_width-1:0] port_read;
    logic [3:0] mismatch;
    logic change_event;
    logic port_rd;
    logic port_wr;
    port_b_pkg::clk_src_t clk_src;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_addr);
        hit = (a == ref_addr);
    endfunction : hit

    assign port_rd = bus_rd && hit(bus_addr, port_b_pkg::second_io_port_addr);
    assign port_wr = bus_wr && hit(bus_addr, port_b_pkg::second_io_port_addr);

    // Pins are taken to idle high after reset, so a pulled-up port raises no false
    // change event while the synchronisers fill; a port idling low will flag once.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_reg <= port_b_pkg::pin_idle_level;
            pin_s2_reg <= port_b_pkg::pin_idle_level;
        end else begin
            pin_s1_reg <= pin_in;
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // Hysteresis: a low pin changes state only when two synced samples agree.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_schmitt
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    schmitt_reg[gi] <= port_b_pkg::pin_idle_level[gi];
                end else if (pin_s2_reg[gi] == s3_reg[gi]) begin
                    schmitt_reg[gi] <= pin_s2_reg[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s3_reg <= port_b_pkg::pin_idle_level[3:0];
        end else begin
            s3_reg <= pin_s2_reg[3:0];
        end
    end

    always_comb begin
        pin_level = pin_s2_reg;
        pin_level[3:0] = schmitt_reg;
    end

    always_comb begin
        clk_src = port_b_pkg::clk_src_none;
        if (counter_control_reg[port_b_pkg::count_clock_select_bit]) begin
            if (counter_control_reg[port_b_pkg::aux_osc_enable_bit]) begin
                clk_src = port_b_pkg::clk_src_aux_osc;
            end else if (ext_clock_pin_select_reg) begin
                clk_src = port_b_pkg::clk_src_external;
            end else begin
                clk_src = port_b_pkg::clk_src_firmware;
            end
        end
    end

    assign aux_osc_active = (clk_src == port_b_pkg::clk_src_aux_osc);

    always_comb begin
        case (clk_src)
            port_b_pkg::clk_src_external: count_clock = pin_level[1];
            port_b_pkg::clk_src_firmware: count_clock = firmware_clock_pin_reg;
            port_b_pkg::clk_src_aux_osc: count_clock = pin_level[1];
            default: count_clock = 1'b0;
        endcase
    end

    // Direction after peripheral overrides; force-out has priority over force-in.
    always_comb begin
        eff_dir = direction_reg;
        for (int i = 1; i < 4; i++) begin
            if (periph_enable_reg[i] && periph_force_out[i]) begin
                eff_dir[i] = 1'b0;
            end else if (periph_enable_reg[i] && periph_force_in[i]) begin
                eff_dir[i] = 1'b1;
            end
        end
    end

    always_comb begin
        pin_out = latch_reg;
        pin_oe = ~eff_dir;
        for (int i = 1; i < 4; i++) begin
            if (periph_enable_reg[i] && periph_force_out[i]) begin
                pin_out[i] = periph_out[i];
            end
        end
        case (clk_src)
            port_b_pkg::clk_src_external: pin_oe[1] = 1'b0;
            port_b_pkg::clk_src_firmware: begin
                pin_out[1] = firmware_clock_pin_reg;
                pin_oe[1] = 1'b1;
            end
            port_b_pkg::clk_src_aux_osc: pin_oe[2:1] = 2'h0;
            default: ; // Timer or off mode leaves pins plain I/O.
        endcase
    end

    always_comb begin
        for (int i = 0; i < port_width; i++) begin
            port_read[i] = direction_reg[i] ? pin_level[i] : latch_reg[i];
        end
        if (clk_src != port_b_pkg::clk_src_none && direction_reg[1]) begin
            port_read[1] = 1'b0;
        end
        if (clk_src == port_b_pkg::clk_src_aux_osc && direction_reg[2]) begin
            port_read[2] = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            direction_reg <= port_b_pkg::direction_reset;
            latch_reg <= '0;
        end else if (bus_wr) begin
            if (port_wr) begin
                latch_reg <= bus_wdata;
            end
            if (hit(bus_addr, port_b_pkg::second_port_direction_addr)) begin
                direction_reg <= bus_wdata;
            end
        end
    end

    // Snapshot on every port access; a write also re-arms so the mismatch ends.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            snapshot_reg <= port_b_pkg::pin_idle_level[7:4];
        end else if (port_rd || port_wr) begin
            snapshot_reg <= pin_level[7:4];
        end
    end

    assign mismatch = (pin_level[7:4] ^ snapshot_reg) & direction_reg[7:4];
    assign change_event = (|mismatch) && !(port_rd || port_wr);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            port_change_flag_reg <= 1'b0;
            port_change_enable_reg <= 1'b0;
        end else begin
            if (bus_wr && hit(bus_addr, port_b_pkg::interrupt_control_addr)) begin
                port_change_flag_reg <= bus_wdata[port_b_pkg::port_change_flag_bit];
                port_change_enable_reg <= bus_wdata[port_b_pkg::port_change_enable_bit];
            end
            if (change_event) begin
                port_change_flag_reg <= 1'b1;
            end
        end
    end

    assign wake_request = sleeping && port_change_enable_reg && port_change_flag_reg;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            counter_control_reg <= port_b_pkg::counter_control_reset;
            firmware_clock_pin_reg <= 1'b0;
            ext_clock_pin_select_reg <= 1'b0;
            periph_enable_reg <= '0;
        end else if (bus_wr) begin
            if (hit(bus_addr, port_b_pkg::counter_control_addr)) begin
                counter_control_reg <= bus_wdata[5:0];
            end
            if (hit(bus_addr, port_b_pkg::pin_data_shadow_addr)) begin
                firmware_clock_pin_reg <= bus_wdata[port_b_pkg::firmware_clock_pin_bit];
            end
            if (hit(bus_addr, port_b_pkg::periph_override_addr)) begin
                ext_clock_pin_select_reg <= bus_wdata[port_b_pkg::ext_clock_pin_select_bit];
                periph_enable_reg <= bus_wdata[7:5];
            end
        end
    end

    // Status bit 0 is a port change, bit 1 a count clock source switch.
    logic [1:0] int_event;
    port_b_pkg::clk_src_t clk_src_prev_reg;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_src_prev_reg <= port_b_pkg::clk_src_none;
        end else begin
            clk_src_prev_reg <= clk_src;
        end
    end
    assign int_event = {clk_src != clk_src_prev_reg, change_event};

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_status_reg <= '0;
            int_mask_reg <= '0;
        end else begin
            if (bus_wr && hit(bus_addr, port_b_pkg::int_mask_addr)) begin
                int_mask_reg <= bus_wdata[1:0];
            end
            if (bus_wr && hit(bus_addr, port_b_pkg::int_status_addr)) begin
                int_status_reg <= (int_status_reg & ~bus_wdata[1:0]) | int_event;
            end else begin
                int_status_reg <= int_status_reg | int_event;
            end
        end
    end

    assign irq = |(int_status_reg & int_mask_reg);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_rdata <= port_b_pkg::zero_byte;
        end else if (bus_rd) begin
            case (bus_addr)
                port_b_pkg::second_io_port_addr: bus_rdata <= port_read;
                port_b_pkg::second_port_direction_addr: bus_rdata <= direction_reg;
                port_b_pkg::pin_data_shadow_addr: begin
                    bus_rdata <= port_b_pkg::zero_byte;
                    if (clk_src == port_b_pkg::clk_src_firmware) begin
                        bus_rdata[0] <= firmware_clock_pin_reg;
                    end else if (clk_src == port_b_pkg::clk_src_external) begin
                        bus_rdata[0] <= pin_level[1];
                    end
                end
                port_b_pkg::interrupt_control_addr:
                    bus_rdata <= {4'h0, port_change_enable_reg, 2'h0, port_change_flag_reg};
                port_b_pkg::counter_control_addr: bus_rdata <= {2'h0, counter_control_reg};
                port_b_pkg::periph_override_addr:
                    bus_rdata <= {periph_enable_reg, 2'h0, ext_clock_pin_select_reg, 2'h0};
                port_b_pkg::int_status_addr: bus_rdata <= {6'h00, int_status_reg};
                port_b_pkg::int_mask_addr: bus_rdata <= {6'h00, int_mask_reg};
                default: bus_rdata <= port_b_pkg::zero_byte;
            endcase
        end else begin
            bus_rdata <= port_b_pkg::zero_byte;
        end
    end

    chk_reset_inputs: assert property (@(posedge sys_clk)
        $rose(rst_n) |-> pin_oe == '0)
        else $error("pins not inputs after reset");
    chk_output_excluded: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ((pin_level[7:4] ^ snapshot_reg) & direction_reg[7:4]) == 4'h0 |-> !change_event)
        else $error("output pin caused change");
    chk_change_sets_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
        change_event |=> port_change_flag_reg)
        else $error("change flag not set");
    chk_access_ends: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (port_rd || port_wr) ##1 $stable(pin_level[7:4]) |-> mismatch == 4'h0)
        else $error("mismatch survived access");
    chk_flag_or: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (|mismatch && !port_rd && !port_wr) |=> port_change_flag_reg)
        else $error("mismatch not ORed to flag");
    chk_wake: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (change_event && sleeping && port_change_enable_reg) ##1 sleeping |-> wake_request)
        else $error("no wake on change");
    chk_firm_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clk_src == port_b_pkg::clk_src_firmware) |-> pin_oe[1] && pin_out[1] == count_clock)
        else $error("firmware clock not on pin");
    chk_aux_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
        aux_osc_active |-> pin_oe[2:1] == 2'h0)
        else $error("aux oscillator pins driven");
    chk_ext_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clk_src == port_b_pkg::clk_src_external) |-> !pin_oe[1] && count_clock == pin_level[1])
        else $error("external clock pin driven");
    chk_status_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
        change_event |=> int_status_reg[0])
        else $error("change status not set");
    chk_schmitt_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (pin_s2_reg[0] != s3_reg[0]) |=> $stable(schmitt_reg[0]))
        else $error("low pin followed one sample");
    chk_timer_plain: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clk_src == port_b_pkg::clk_src_none && periph_enable_reg == 3'h0)
        |-> pin_oe == ~direction_reg && pin_out == latch_reg)
        else $error("plain pins not driven from latch");
    cov_change: cover property (@(posedge sys_clk) disable iff (!rst_n) change_event);
    cov_wake: cover property (@(posedge sys_clk) disable iff (!rst_n) wake_request);
    cov_aux: cover property (@(posedge sys_clk) disable iff (!rst_n) aux_osc_active);
    cov_ext: cover property (@(posedge sys_clk) disable iff (!rst_n)
        clk_src == port_b_pkg::clk_src_external);
    cov_firm: cover property (@(posedge sys_clk) disable iff (!rst_n)
        clk_src == port_b_pkg::clk_src_firmware);
endmodule : port_b_change_and_mux

// ==== core/port_b_pkg.sv ====
// Package with register offsets, field positions and reset values for the second I/O port.
package port_b_pkg;
    localparam logic [7:0] second_io_port_addr = 8'h06;
    localparam logic [7:0] pin_data_shadow_addr = 8'h07;
    localparam logic [7:0] interrupt_control_addr = 8'h0b;
    localparam logic [7:0] counter_control_addr = 8'h10;
    localparam logic [7:0] second_port_direction_addr = 8'h86;
    localparam logic [7:0] periph_override_addr = 8'h87;
    localparam logic [7:0] int_status_addr = 8'h88;
    localparam logic [7:0] int_mask_addr = 8'h89;
    localparam int port_change_flag_bit = 0;
    localparam int port_change_enable_bit = 3;
    localparam int counter_run_enable_bit = 0;
    localparam int count_clock_select_bit = 1;
    localparam int aux_osc_enable_bit = 3;
    localparam int firmware_clock_pin_bit = 0;
    localparam int ext_clock_pin_select_bit = 2;
    localparam logic [7:0] direction_reset = 8'hff;
    localparam logic [7:0] zero_byte = 8'h00;
    localparam logic [7:0] pin_idle_level = 8'hff;
    localparam logic [5:0] counter_control_reset = 6'h00;
    typedef enum logic [1:0] {
        clk_src_none,
        clk_src_external,
        clk_src_firmware,
        clk_src_aux_osc
    } clk_src_t;
endpackage : port_b_pkg

// ==== sim/pin_world.sv ====
// Model of the keys and pull-up resistors that sit on the port pins.
`timescale 1ns/1ps
module pin_world (
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] key_down,
    output logic [7:0] pin_in
);
    // A released pin is pulled up unless a key grounds it.
    // The bench never presses a key on a driven pin, since that would fight the driver.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i]) begin
                pin_in[i] = pin_out[i];
            end else begin
                pin_in[i] = ~key_down[i];
            end
        end
    end
endmodule : pin_world

// ==== sim/port_b_change_and_mux_tb_top.sv ====
// Self-checking testbench for the second I/O port with change detection and clock muxing.
`timescale 1ns/1ps
module port_b_change_and_mux_tb_top;
    localparam logic [7:0] a_port = port_b_pkg::second_io_port_addr;
    localparam logic [7:0] a_shadow = port_b_pkg::pin_data_shadow_addr;
    localparam logic [7:0] a_interrupt_control_reg = port_b_pkg::interrupt_control_addr;
    localparam logic [7:0] a_ctrl = port_b_pkg::counter_control_addr;
    localparam logic [7:0] a_dir = port_b_pkg::second_port_direction_addr;
    localparam logic [7:0] a_ovr = port_b_pkg::periph_override_addr;
    localparam logic [7:0] a_status = port_b_pkg::int_status_addr;
    localparam logic [7:0] a_mask = port_b_pkg::int_mask_addr;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] bus_addr = 8'h00;
    logic [7:0] bus_wdata = 8'h00;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [7:0] bus_rdata;
    logic [7:0] pin_in;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic [7:0] key_down = 8'h00;
    logic [3:1] periph_out = 3'h0;
    logic [3:1] periph_force_out = 3'h0;
    logic [3:1] periph_force_in = 3'h0;
    logic sleeping = 1'b0;
    logic wake_request;
    logic count_clock;
    logic aux_osc_active;
    logic irq;
    logic [7:0] rd_val;
    int error_cnt = 0;
    int checked = 0;

    always #12.5 sys_clk = ~sys_clk;

    port_b_change_and_mux dut (.sys_clk(sys_clk), .rst_n(rst_n), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .periph_out(periph_out),
        .periph_force_out(periph_force_out), .periph_force_in(periph_force_in),
        .sleeping(sleeping), .wake_request(wake_request), .count_clock(count_clock),
        .aux_osc_active(aux_osc_active), .irq(irq));

    pin_world keys (.pin_out(pin_out), .pin_oe(pin_oe), .key_down(key_down), .pin_in(pin_in));

    task automatic finish_test();
        if (error_cnt == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic reg_wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge sys_clk);
        bus_addr <= addr;
        bus_wdata <= data;
        bus_wr <= 1'b1;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
    endtask : reg_wr

    // Read data stand only in the cycle after the strobe, so they are taken mid-cycle.
    task automatic reg_rd(input logic [7:0] addr);
        @(posedge sys_clk);
        bus_addr <= addr;
        bus_rd <= 1'b1;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        @(negedge sys_clk);
        rd_val = bus_rdata;
    endtask : reg_rd

    task automatic look(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : look

    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        chk("irq_raised", irq, 1'b1);
        if (irq !== 1'b1) begin
            finish_test();
        end
    endtask : wait_irq

    initial begin
        look(10);
        chk("oe_in_reset", pin_oe, 8'h00);
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        reg_rd(a_dir);
        chk("dir_reset", rd_val, port_b_pkg::direction_reset);
        reg_wr(8'h30, 8'h5a);
        reg_rd(8'h30);
        chk("unmapped", rd_val, 8'h00);
        // The port is read only where a snapshot is wanted, never polled.
        reg_wr(a_interrupt_control_reg, 8'h08);
        reg_rd(a_port);
        chk("port_snap", rd_val, 8'hff);
        @(posedge sys_clk);
        key_down <= 8'h20;
        look(8);
        chk("irq_masked", irq, 1'b0);
        reg_rd(a_interrupt_control_reg);
        chk("flag_set", rd_val[0], 1'b1);
        reg_rd(a_status);
        chk("status_set", rd_val[0], 1'b1);
        reg_wr(a_mask, 8'h01);
        wait_irq();
        @(posedge sys_clk);
        sleeping <= 1'b1;
        look(2);
        chk("wake", wake_request, 1'b1);
        reg_wr(a_interrupt_control_reg, 8'h08);
        look(3);
        reg_rd(a_interrupt_control_reg);
        chk("flag_held", rd_val[0], 1'b1);
        reg_rd(a_port);
        chk("port_read", rd_val, 8'hdf);
        reg_wr(a_interrupt_control_reg, 8'h08);
        reg_wr(a_status, 8'h01);
        look(3);
        reg_rd(a_interrupt_control_reg);
        chk("flag_clear", rd_val[0], 1'b0);
        chk("irq_clear", irq, 1'b0);
        chk("wake_clear", wake_request, 1'b0);
        @(posedge sys_clk);
        key_down <= 8'h00;
        sleeping <= 1'b0;
        look(6);
        reg_wr(a_port, 8'h00);
        reg_wr(a_interrupt_control_reg, 8'h08);
        reg_wr(a_status, 8'h01);
        look(2);
        reg_rd(a_interrupt_control_reg);
        chk("flag_after_wr", rd_val[0], 1'b0);
        reg_wr(a_dir, 8'hef);
        @(posedge sys_clk);
        key_down <= 8'h01;
        look(8);
        chk("oe_out", pin_oe, 8'h10);
        chk("drive_latch", pin_out[4], 1'b0);
        reg_rd(a_interrupt_control_reg);
        chk("no_flag", rd_val[0], 1'b0);
        reg_rd(a_port);
        chk("port_mix", rd_val, 8'hee);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        key_down <= 8'h00;
        look(2);
        chk("oe_rst2", pin_oe, 8'h00);
        @(posedge sys_clk);
        rst_n <= 1'b1;
        key_down <= 8'h01;
        @(posedge sys_clk);
        key_down <= 8'h00;
        look(6);
        reg_rd(a_port);
        chk("glitch_gone", rd_val, 8'hff);
        // Direction is set before the overrides, never read-modify-written under them.
        reg_wr(a_dir, 8'hf7);
        reg_wr(a_ovr, 8'he0);
        @(posedge sys_clk);
        periph_out <= 3'b010;
        periph_force_out <= 3'b010;
        periph_force_in <= 3'b100;
        look(1);
        chk("ovr_oe", pin_oe[3:1], 3'b010);
        chk("ovr_out", pin_out[2], 1'b1);
        @(posedge sys_clk);
        periph_force_out <= 3'b000;
        periph_force_in <= 3'b000;
        look(1);
        chk("ovr_off", pin_oe[3:1], 3'b100);
        reg_wr(a_ovr, 8'h00);
        reg_wr(a_dir, 8'hf9);
        reg_wr(a_port, 8'h06);
        reg_wr(a_ctrl, 8'h01);
        look(1);
        chk("timer_io", {pin_oe[2:1], pin_out[2:1]}, 8'h0f);
        reg_wr(a_dir, 8'hff);
        reg_wr(a_ovr, 8'h04);
        reg_wr(a_ctrl, 8'h03);
        @(posedge sys_clk);
        key_down <= 8'h02;
        look(6);
        chk("ext_clk_lo", count_clock, 1'b0);
        @(posedge sys_clk);
        key_down <= 8'h00;
        look(6);
        chk("ext_clk_hi", count_clock, 1'b1);
        reg_rd(a_port);
        chk("ext_rd0", rd_val, 8'hfd);
        reg_wr(a_ovr, 8'h00);
        reg_wr(a_shadow, 8'h01);
        look(2);
        chk("fw_clk", {count_clock, pin_oe[1], pin_out[1]}, 8'h07);
        reg_rd(a_shadow);
        chk("fw_bit", rd_val[0], 1'b1);
        reg_wr(a_shadow, 8'h00);
        look(2);
        chk("fw_clk_lo", {count_clock, pin_out[1]}, 8'h00);
        reg_wr(a_ctrl, 8'h0b);
        look(2);
        chk("aux_on", aux_osc_active, 1'b1);
        reg_rd(a_port);
        chk("aux_rd0", rd_val, 8'hf9);
        reg_rd(a_status);
        chk("src_event", rd_val[1], 1'b1);
        reg_wr(a_status, 8'h02);
        reg_rd(a_status);
        chk("src_event_clr", rd_val[1], 1'b0);
        finish_test();
    end
endmodule : port_b_change_and_mux_tb_top
